// File: pkg/link_ctl_pkg.sv
package link_ctl_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_MSG_LIM   = 8'h08;
  localparam logic [7:0] REG_OCT_LIM   = 8'h0c;
  localparam logic [7:0] REG_T_READY   = 8'h10;
  localparam logic [7:0] REG_T_NALIGN  = 8'h14;
  localparam logic [7:0] REG_T_ALIGN   = 8'h18;
  localparam logic [7:0] REG_T_PROVE_N = 8'h1c;
  localparam logic [7:0] REG_T_PROVE_E = 8'h20;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTRL_START  = 0;
  localparam int CTRL_STOP   = 1;
  localparam int CTRL_EMERG  = 2;
  localparam int CTRL_RESUME = 3;

  // ----------------------------------------
  // Status register fields
  // ----------------------------------------
  localparam int STS_STATE  = 0;
  localparam int STS_ABORTS = 4;
  localparam int STS_FORCED = 8;
  localparam int STS_OUTAGE = 9;
  localparam int STS_FSN    = 16;

  // ----------------------------------------
  // Link status indication codes
  // ----------------------------------------
  localparam logic [2:0] IND_O  = 3'h0;
  localparam logic [2:0] IND_N  = 3'h1;
  localparam logic [2:0] IND_E  = 3'h2;
  localparam logic [2:0] IND_OS = 3'h3;
  localparam logic [2:0] IND_PO = 3'h4;
  localparam logic [2:0] IND_NONE = 3'h7;

  // ----------------------------------------
  // Limits and thresholds
  // ----------------------------------------
  localparam logic [6:0] MSG_LIM_MAX  = 7'h7f;
  localparam logic [6:0] MSG_LIM_RST  = 7'h7f;
  localparam logic [15:0] OCT_LIM_RST = 16'h0400;
  localparam logic [2:0] ABORT_NORMAL = 3'h4;
  localparam logic [2:0] ABORT_EMERG  = 3'h1;
  localparam logic [2:0] ABORT_MAX    = 3'h5;
  localparam logic [6:0] FSN_RST      = 7'h7f;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint CLK_PERIOD_PS   = 4000;
  localparam longint OCTET_TIME_PS   = 125000000;
  localparam longint PROVE_N_OCTETS  = 65536;
  localparam longint PROVE_E_OCTETS  = 4096;
  localparam longint PROVE_N_CYC = PROVE_N_OCTETS * OCTET_TIME_PS / CLK_PERIOD_PS;
  localparam longint PROVE_E_CYC = PROVE_E_OCTETS * OCTET_TIME_PS / CLK_PERIOD_PS;
  localparam logic [31:0] T_PROVE_N_RST = PROVE_N_CYC[31:0];
  localparam logic [31:0] T_PROVE_E_RST = PROVE_E_CYC[31:0];
  localparam logic [31:0] T_READY_RST   = 32'h0001_0000;
  localparam logic [31:0] T_NALIGN_RST  = 32'h0001_0000;
  localparam logic [31:0] T_ALIGN_RST   = 32'h0001_0000;
endpackage

// File: hdl/phase_timer.sv
module phase_timer #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control
  input  wire logic             start,
  input  wire logic             stop,
  input  wire logic [WIDTH-1:0] period,
  // Status
  output logic                  running,
  output logic                  expired
);
  logic [WIDTH-1:0] count;

  // Start wins over stop so a restart in the leaving cycle is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count   <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        count   <= (period == '0) ? '0 : period - 1'b1;
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running) begin
        if (count == '0) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end
endmodule

// File: hdl/link_ctl.sv
// Design decisions made here: the APB register port and the address map.
module link_ctl
  import link_ctl_pkg::*;
#(
  parameter logic [31:0] T_READY_INIT   = link_ctl_pkg::T_READY_RST,
  parameter logic [31:0] T_NALIGN_INIT  = link_ctl_pkg::T_NALIGN_RST,
  parameter logic [31:0] T_ALIGN_INIT   = link_ctl_pkg::T_ALIGN_RST,
  parameter logic [31:0] T_PROVE_N_INIT = link_ctl_pkg::T_PROVE_N_RST,
  parameter logic [31:0] T_PROVE_E_INIT = link_ctl_pkg::T_PROVE_E_RST
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Receive side events
  input  wire logic        rx_lssu,
  input  wire logic [2:0]  rx_ind,
  input  wire logic        rx_unit,
  input  wire logic        align_error,
  // Retransmission buffer
  input  wire logic [6:0]  buffered_message_count,
  input  wire logic [15:0] buffered_octet_count,
  input  wire logic        rtx_sent,
  input  wire logic        msu_assign,
  // Level 3 side
  input  wire logic        local_outage,
  // Transmit control
  output logic             tx_lssu,
  output logic [2:0]       tx_ind,
  output logic             hold_new,
  output logic             forced_active,
  output logic [6:0]       rtx_index,
  output logic [6:0]       fsn,
  output logic             discard_rx,
  output logic             flush,
  output logic             in_service,
  output logic             link_fail
);
  typedef enum logic [2:0] {
    st_idle, st_not_aligned, st_aligned, st_proving, st_ready, st_service
  } align_e;

  align_e      state;
  logic        emerg;
  logic [6:0]  msg_lim;
  logic [15:0] oct_lim;
  logic [31:0] t_ready, t_nalign, t_align, t_prove_n, t_prove_e;
  logic        cmd_start, cmd_stop, cmd_resume;
  logic        peer_e, short_prove;
  logic [2:0]  err_cnt, aborts;
  logic        outage_hold;
  logic [6:0]  rtx_last;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic wr_en, setup, mapped;
  logic [31:0] rd_mux;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;
  assign mapped = (paddr <= REG_T_PROVE_E) && (paddr[1:0] == 2'h0);

  always_comb begin
    rd_mux = 32'h0;
    unique case (paddr)
      REG_CTRL:      rd_mux[CTRL_EMERG] = emerg;
      REG_STATUS: begin
        rd_mux[STS_STATE +: 3]  = state;
        rd_mux[STS_ABORTS +: 3] = aborts;
        rd_mux[STS_FORCED]      = forced_active;
        rd_mux[STS_OUTAGE]      = outage_hold;
        rd_mux[STS_FSN +: 7]    = fsn;
      end
      REG_MSG_LIM:   rd_mux[6:0]  = msg_lim;
      REG_OCT_LIM:   rd_mux[15:0] = oct_lim;
      REG_T_READY:   rd_mux = t_ready;
      REG_T_NALIGN:  rd_mux = t_nalign;
      REG_T_ALIGN:   rd_mux = t_align;
      REG_T_PROVE_N: rd_mux = t_prove_n;
      REG_T_PROVE_E: rd_mux = t_prove_e;
      default:       rd_mux = 32'h0;
    endcase
  end

  // One wait-free access cycle: answer is registered during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emerg     <= 1'b0;
      msg_lim   <= MSG_LIM_RST;
      oct_lim   <= OCT_LIM_RST;
      t_ready   <= T_READY_INIT;
      t_nalign  <= T_NALIGN_INIT;
      t_align   <= T_ALIGN_INIT;
      t_prove_n <= T_PROVE_N_INIT;
      t_prove_e <= T_PROVE_E_INIT;
    end else if (wr_en) begin
      unique case (paddr)
        REG_CTRL:      emerg <= pwdata[CTRL_EMERG];
        // Values above the sequence range are clamped
        REG_MSG_LIM:   msg_lim <= (pwdata > {25'h0, MSG_LIM_MAX}) ? MSG_LIM_MAX
                                  : pwdata[6:0];
        REG_OCT_LIM:   oct_lim <= pwdata[15:0];
        REG_T_READY:   t_ready <= pwdata;
        REG_T_NALIGN:  t_nalign <= pwdata;
        REG_T_ALIGN:   t_align <= pwdata;
        REG_T_PROVE_N: t_prove_n <= pwdata;
        REG_T_PROVE_E: t_prove_e <= pwdata;
        default: ;
      endcase
    end
  end

  assign cmd_start  = wr_en && paddr == REG_CTRL && pwdata[CTRL_START];
  assign cmd_stop   = wr_en && paddr == REG_CTRL && pwdata[CTRL_STOP];
  assign cmd_resume = wr_en && paddr == REG_CTRL && pwdata[CTRL_RESUME];

  // ----------------------------------------
  // Alignment timers
  // ----------------------------------------
  logic nal_go, al_go, pr_go, rd_go;
  logic nal_exp, al_exp, pr_exp, rd_exp;
  logic nal_run, al_run, pr_run, rd_run;
  logic [31:0] pr_period;
  align_e next_state;

  assign pr_period = short_prove ? t_prove_e : t_prove_n;

  // Each timer loads its register on state entry and stops on leaving
  phase_timer u_nal (.pclk(pclk), .presetn(presetn), .start(nal_go),
    .stop(next_state != st_not_aligned), .period(t_nalign),
    .running(nal_run), .expired(nal_exp));
  phase_timer u_al (.pclk(pclk), .presetn(presetn), .start(al_go),
    .stop(next_state != st_aligned), .period(t_align),
    .running(al_run), .expired(al_exp));
  phase_timer u_pr (.pclk(pclk), .presetn(presetn), .start(pr_go),
    .stop(next_state != st_proving), .period(pr_period),
    .running(pr_run), .expired(pr_exp));
  phase_timer u_rd (.pclk(pclk), .presetn(presetn), .start(rd_go),
    .stop(next_state != st_ready), .period(t_ready),
    .running(rd_run), .expired(rd_exp));

  // ----------------------------------------
  // Alignment state machine
  // ----------------------------------------
  logic rx_o, rx_ne, rx_os, abort_now, fail_now;
  assign rx_o  = rx_lssu && rx_ind == IND_O;
  assign rx_ne = rx_lssu && (rx_ind == IND_N || rx_ind == IND_E);
  assign rx_os = rx_lssu && rx_ind == IND_OS;
  assign abort_now = state == st_proving && align_error &&
                     err_cnt + 3'h1 >= (short_prove ? ABORT_EMERG : ABORT_NORMAL);

  always_comb begin
    next_state = state;
    fail_now   = 1'b0;
    unique case (state)
      st_idle: if (cmd_start) next_state = st_not_aligned;
      st_not_aligned:
        if (rx_o || rx_ne) next_state = st_aligned;
        else if (nal_exp) fail_now = 1'b1;
      st_aligned:
        if (rx_ne) next_state = st_proving;
        else if (rx_os || al_exp) fail_now = 1'b1;
      st_proving:
        if (rx_os || (abort_now && aborts + 3'h1 >= ABORT_MAX))
          fail_now = 1'b1;
        else if (rx_o) next_state = st_aligned;
        else if (pr_exp && !abort_now) next_state = st_ready;
      st_ready:
        if (rx_unit) next_state = st_service;
        else if (rx_os || rd_exp) fail_now = 1'b1;
      st_service:
        if (rx_lssu && rx_ind != IND_PO) fail_now = 1'b1;
    endcase
    if (fail_now || cmd_stop) next_state = st_idle;
  end

  assign nal_go = next_state == st_not_aligned && state != st_not_aligned;
  assign al_go  = next_state == st_aligned && state != st_aligned;
  assign pr_go  = next_state == st_proving && (state != st_proving || abort_now);
  assign rd_go  = next_state == st_ready && state != st_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= st_idle;
      link_fail <= 1'b0;
    end else begin
      state     <= next_state;
      link_fail <= fail_now;
    end
  end

  // Peer emergency is remembered per attempt, never copied into emerg
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peer_e <= 1'b0;
    end else if (state == st_idle) begin
      peer_e <= 1'b0;
    end else if (rx_lssu && rx_ind == IND_E) begin
      peer_e <= 1'b1;
    end
  end
  assign short_prove = emerg || peer_e;

  // Error counter restarted with each proving period, abort counter cleared in idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_cnt <= 3'h0;
      aborts  <= 3'h0;
    end else begin
      if (pr_go) err_cnt <= 3'h0;
      else if (state == st_proving && align_error) err_cnt <= err_cnt + 3'h1;
      if (state == st_idle) aborts <= 3'h0;
      else if (abort_now) aborts <= aborts + 3'h1;
    end
  end

  // ----------------------------------------
  // Processor outage
  // ----------------------------------------
  // Outage is held until level 3 permits resumption after the cause clears
  logic outage_end;
  assign outage_end = outage_hold && !local_outage && cmd_resume;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outage_hold <= 1'b0;
      flush       <= 1'b0;
      discard_rx  <= 1'b0;
    end else begin
      if (local_outage) outage_hold <= 1'b1;
      else if (outage_end) outage_hold <= 1'b0;
      flush      <= outage_end;
      discard_rx <= local_outage || (outage_hold && !outage_end);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsn <= FSN_RST;
    end else if (outage_end) begin
      fsn <= FSN_RST;
    end else if (msu_assign) begin
      fsn <= fsn + 7'h1;
    end
  end

  // ----------------------------------------
  // Transmitted status
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_lssu    <= 1'b1;
      tx_ind     <= IND_OS;
      in_service <= 1'b0;
    end else begin
      tx_lssu    <= 1'b1;
      in_service <= next_state == st_service;
      unique case (next_state)
        st_idle:        tx_ind <= IND_OS;
        st_not_aligned: tx_ind <= IND_O;
        st_aligned, st_proving:
          tx_ind <= emerg ? IND_E : IND_N;
        default: begin
          tx_ind  <= (local_outage || outage_hold) ? IND_PO : IND_NONE;
          tx_lssu <= local_outage || outage_hold;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Forced retransmission
  // ----------------------------------------
  logic at_limit;
  assign at_limit = buffered_message_count != 7'h0 &&
                    (buffered_message_count >= msg_lim ||
                     buffered_octet_count >= oct_lim);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forced_active <= 1'b0;
      rtx_index     <= 7'h0;
      rtx_last      <= 7'h0;
    end else if (outage_end) begin
      forced_active <= 1'b0;
      rtx_index     <= 7'h0;
    end else if (!forced_active) begin
      if (at_limit) begin
        forced_active <= 1'b1;
        rtx_index     <= 7'h0;
        rtx_last      <= buffered_message_count - 7'h1;
      end
    end else if (rtx_sent) begin
      if (rtx_index != rtx_last) begin
        rtx_index <= rtx_index + 7'h1;
      end else begin
        forced_active <= at_limit;
        rtx_index     <= 7'h0;
        rtx_last      <= buffered_message_count - 7'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_new <= 1'b0;
    end else begin
      hold_new <= (forced_active && !(rtx_sent && rtx_index == rtx_last && !at_limit))
                  || (!forced_active && at_limit);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_idle_sends_os: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_idle && $past(state) == st_idle |-> tx_ind == IND_OS)
    else $error("idle state not sending out-of-service");
  chk_nal_timer_runs: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state == st_not_aligned) |=> nal_run || state != st_not_aligned)
    else $error("not-aligned timer not running");
  chk_own_status_kept: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_proving && !emerg && $past(state) == st_proving |-> tx_ind == IND_N)
    else $error("normal terminal sent emergency status");
  chk_ready_needs_expiry: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_ready && $past(state) == st_proving |-> $past(pr_exp))
    else $error("aligned-ready entered without full proving");
  chk_abort_limit: assert property (@(posedge pclk) disable iff (!presetn)
    abort_now && aborts == 3'h4 |=> state == st_idle && link_fail ##1 aborts == 3'h0)
    else $error("fifth abort did not end alignment");
  chk_msg_limit_clamp: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == REG_MSG_LIM && pwdata > {25'h0, MSG_LIM_MAX} |=> msg_lim == MSG_LIM_MAX)
    else $error("message limit above 127");
  chk_forced_holds: assert property (@(posedge pclk) disable iff (!presetn)
    !forced_active && at_limit |=> forced_active && hold_new && rtx_index == 7'h0)
    else $error("limit reached without forced retransmission");
  chk_outage_po: assert property (@(posedge pclk) disable iff (!presetn)
    local_outage && state == st_service && !cmd_stop && !rx_lssu
    |=> tx_ind == IND_PO && discard_rx)
    else $error("outage not signalled");
  chk_fsn_step: assert property (@(posedge pclk) disable iff (!presetn)
    msu_assign && !outage_end |=> fsn == $past(fsn) + 7'h1)
    else $error("sequence number not advanced by one");
  chk_flush_resync: assert property (@(posedge pclk) disable iff (!presetn)
    outage_end |=> flush && fsn == FSN_RST && !forced_active)
    else $error("outage end did not flush");
endmodule

// File: dv/far_end.sv
module far_end (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Peer alignment status
  input  wire logic [2:0] own_ind,
  // Link from and to the terminal
  input  wire logic       tx_lssu,
  input  wire logic [2:0] tx_ind,
  output logic            rx_lssu,
  output logic [2:0]      rx_ind,
  output logic            rx_unit
);
  timeunit 1ns;
  timeprecision 1ps;
  import link_ctl_pkg::*;
  logic [2:0] last;
  // Answer each new alignment indication once, with the peer's own status
  wire ans = tx_lssu && tx_ind != last && tx_ind <= IND_E;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last    <= IND_NONE;
      rx_lssu <= 1'b0;
      rx_ind  <= IND_OS;
      rx_unit <= 1'b0;
    end else begin
      last    <= tx_lssu ? tx_ind : IND_NONE;
      rx_lssu <= ans;
      // Code lines toggle outside a status unit so no stale value lingers
      rx_ind  <= ans ? own_ind : ~rx_ind;
      rx_unit <= !tx_lssu || tx_ind == IND_PO;
    end
  end
endmodule

// File: dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import link_ctl_pkg::*;
  localparam logic [31:0] T_PN = 32'hc8;
  localparam logic [31:0] T_PE = 32'h32;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, seen = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, rx_lssu, rx_unit, rtx_sent = 1'b0, msu_assign = 1'b0;
  logic        local_outage = 1'b0, tx_lssu, hold_new, forced_active, discard_rx, flush;
  logic        in_service, link_fail, align_error = 1'b0;
  logic [2:0]  rx_ind, tx_ind, own_ind = IND_N;
  logic [6:0]  msg_cnt = 7'h00, rtx_index, fsn;
  logic [15:0] oct_cnt = 16'h0000;
  int          failures = 0, total_checks = 0, cycles = 0, flushes = 0, fails = 0;
  always #2 pclk = ~pclk;
  link_ctl #(.T_READY_INIT(32'h190), .T_NALIGN_INIT(32'h190), .T_ALIGN_INIT(32'h190),
             .T_PROVE_N_INIT(T_PN), .T_PROVE_E_INIT(T_PE)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .rx_lssu, .rx_ind, .rx_unit, .align_error, .buffered_message_count(msg_cnt),
    .buffered_octet_count(oct_cnt), .rtx_sent, .msu_assign, .local_outage, .tx_lssu,
    .tx_ind, .hold_new, .forced_active, .rtx_index, .fsn, .discard_rx, .flush,
    .in_service, .link_fail);
  far_end u_far (.pclk, .presetn, .own_ind, .tx_lssu, .tx_ind, .rx_lssu, .rx_ind, .rx_unit);
  // ----------------------------------------
  // Monitors, sampled mid-cycle to stay clear of edge races; the cycle watchdog counts rising edges
  // ----------------------------------------
  always @(negedge pclk) begin
    if (tx_lssu === 1'b1) seen[tx_ind] <= 1'b1;
    if (flush === 1'b1) flushes++;
    if (link_fail === 1'b1) fails++;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is taken at the rising edge that samples pready high
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // 0: new sequence number, 1: resent unit, other: alignment error
  task automatic pulse(input int sel);
    case (sel)
      0: msu_assign <= 1'b1;
      1: rtx_sent <= 1'b1;
      default: align_error <= 1'b1;
    endcase
    @(posedge pclk);
    {msu_assign, rtx_sent, align_error} <= 3'b000;
    @(posedge pclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_regs();
    chk({tx_lssu, tx_ind, fsn}, {1'b1, IND_OS, FSN_RST});
    pulse(0);
    @(posedge pclk);
    chk(fsn, 32'h0);
    apb(1'b0, REG_OCT_LIM, 32'h0);
    chk(rd, 32'h400);
    apb(1'b1, REG_MSG_LIM, 32'hc8);
    apb(1'b0, REG_MSG_LIM, 32'h0);
    chk(rd, 32'h7f);
    apb(1'b1, REG_T_NALIGN, 32'h1a0);
    apb(1'b0, REG_T_NALIGN, 32'h0);
    chk(rd, 32'h1a0);
    apb(1'b0, 8'h24, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    $display("test reset_regs done");
  endtask
  task automatic t_forced();
    apb(1'b1, REG_MSG_LIM, 32'h4);
    msg_cnt <= 7'h4;
    repeat (3) @(posedge pclk);
    chk({forced_active, hold_new}, 2'b11);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        chk(rtx_index, i);
        pulse(1);
      end
      chk(forced_active, p == 0);
      msg_cnt <= 7'h2;
    end
    oct_cnt <= 16'h0400;
    repeat (3) @(posedge pclk);
    chk(hold_new, 1'b1);
    oct_cnt <= 16'h0000;
    msg_cnt <= 7'h0;
    do_reset();
    $display("test forced done");
  endtask
  task automatic t_align(input logic [31:0] ctrl, input logic [2:0] own, input logic [2:0] ind,
                         input int lo, input int hi);
    int n;
    n = 0;
    own_ind <= own;
    seen <= 8'h00;
    apb(1'b1, REG_CTRL, ctrl);
    while (in_service !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk({seen[IND_O], seen[ind], seen[IND_N ^ IND_E ^ ind]}, 3'b110);
    chk(n >= lo && n < hi, 1'b1);
    chk({in_service, tx_lssu}, 2'b10);
    $display("test align done");
  endtask
  task automatic t_outage();
    local_outage <= 1'b1;
    pulse(0);
    @(posedge pclk);
    chk({tx_lssu, tx_ind, discard_rx}, {1'b1, IND_PO, 1'b1});
    local_outage <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({tx_ind, discard_rx}, {IND_PO, 1'b1});
    flushes = 0;
    apb(1'b1, REG_CTRL, 32'h8);
    repeat (3) @(posedge pclk);
    chk({flushes[1:0], fsn}, {2'h1, FSN_RST});
    chk({tx_lssu, discard_rx}, 2'b00);
    apb(1'b1, REG_CTRL, 32'h2);
    repeat (3) @(posedge pclk);
    chk(tx_ind, IND_OS);
    $display("test outage done");
  endtask
  // Emergency proving aborts on every error; the fifth abort ends alignment
  task automatic t_abort();
    apb(1'b1, REG_CTRL, 32'h2);
    apb(1'b1, REG_CTRL, 32'h5);
    repeat (10) @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[STS_STATE +: 3], 3'h3);
    repeat (4) pulse(2);
    apb(1'b0, REG_STATUS, 32'h0);
    chk({rd[STS_ABORTS +: 3], rd[STS_STATE +: 3]}, {3'h4, 3'h3});
    fails = 0;
    pulse(2);
    chk({fails[1:0], tx_ind}, {2'h1, IND_OS});
    apb(1'b0, REG_STATUS, 32'h0);
    chk({rd[STS_ABORTS +: 3], rd[STS_STATE +: 3]}, 6'h00);
    $display("test abort done");
  endtask
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    do_reset();
    t_reset_regs();
    t_forced();
    t_align(32'h1, IND_N, IND_N, T_PN, T_PN + 100);
    t_outage();
    t_align(32'h5, IND_N, IND_E, T_PE, T_PN);
    apb(1'b1, REG_CTRL, 32'h2);
    t_align(32'h1, IND_E, IND_N, T_PE, T_PN);
    t_abort();
    print_verdict();
  end
endmodule
